// >>> rtl/heoc_pkg.sv
// Shared constants and types for the hopping encoder option control block
package heoc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ       = 100;
  localparam int unsigned TE_SLOW_US    = 400;
  localparam int unsigned TE_MID_US     = 200;
  localparam int unsigned TE_FAST_US    = 100;
  localparam int unsigned TE_SLOW_CYC   = TE_SLOW_US * CLK_MHZ;
  localparam int unsigned TE_MID_CYC    = TE_MID_US * CLK_MHZ;
  localparam int unsigned TE_FAST_CYC   = TE_FAST_US * CLK_MHZ;
  localparam int unsigned CARRIER_KHZ   = 40;
  localparam int unsigned CAR_HALF_CYC  = (CLK_MHZ * 1000) / (2 * CARRIER_KHZ);

  // ----------------------------------------------------------------
  // Word counts
  // ----------------------------------------------------------------
  localparam logic [9:0]  DELAY_WORDS_LO = 10'h01C;
  localparam logic [9:0]  DELAY_WORDS_HI = 10'h038;
  localparam logic [9:0]  SHUT_WORDS_LO  = 10'h100;
  localparam logic [9:0]  SHUT_WORDS_HI  = 10'h200;
  localparam logic [9:0]  WORDS_MAX      = 10'h3FF;

  // ----------------------------------------------------------------
  // Temporary learn limits, keyed by preset counter value
  // ----------------------------------------------------------------
  localparam logic [15:0] LIM_KEY_64  = 16'h0060;
  localparam logic [15:0] LIM_KEY_32  = 16'h0050;
  localparam logic [15:0] LIM_KEY_16  = 16'h0048;
  localparam logic [7:0]  LIM_128     = 8'h80;
  localparam logic [7:0]  LIM_64      = 8'h40;
  localparam logic [7:0]  LIM_32      = 8'h20;
  localparam logic [7:0]  LIM_16      = 8'h10;

  // ----------------------------------------------------------------
  // Configuration word fields
  // ----------------------------------------------------------------
  localparam int CFG_RATE0   = 1;
  localparam int CFG_RATE1   = 2;
  localparam int CFG_LEARN   = 4;
  localparam int CFG_DELAYED_MODE_ENABLE    = 5;
  localparam int CFG_SHUT    = 6;
  localparam int CFG_DUAL    = 7;
  localparam int CFG_USER_BITS_A    = 8;
  localparam int CFG_USER_BITS_B    = 10;
  localparam int CFG_LONG_SERIAL_ENABLE    = 12;
  localparam int CFG_TMP     = 13;
  localparam int CFG_BIPHASE_SELECT   = 14;
  localparam int CFG_WRAP    = 15;
  localparam logic [15:0] CFG_RESET = 16'h0000;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CONFIG   = 4'h0;
  localparam logic [3:0] REG_SYNC_A   = 4'h1;
  localparam logic [3:0] REG_SYNC_B   = 4'h2;
  localparam logic [3:0] REG_SER_LO   = 4'h3;
  localparam logic [3:0] REG_SER_HI   = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'h5;
  localparam logic [3:0] REG_HOPCNT   = 4'h6;

  localparam logic [3:0] CODE_LEARN_NOW   = 4'h9;
  localparam logic [3:0] CODE_LEARN_DELAY = 4'h3;

  typedef enum logic [2:0] {
    HEOC_IDLE = 3'h1,
    HEOC_ACT  = 3'h2,
    HEOC_SHUT = 3'h4
  } heoc_state_e;

  typedef struct packed {
    heoc_state_e st;
    logic [3:0]  code;
    logic [15:0] cfg;
    logic [15:0] sess;
    logic [15:0] sync_a;
    logic [15:0] sync_b;
    logic [15:0] ser_lo;
    logic [15:0] ser_hi;
    logic        wrapped;
    logic        learn_off;
    logic [7:0]  hop_cnt;
    logic [7:0]  learn_lim;
    logic [9:0]  words;
    logic        delayed;
    logic        busy;
    logic        bit_val;
    logic [1:0]  slot;
    logic [15:0] te_cnt;
    logic [15:0] car_cnt;
    logic        car;
    logic        tx;
    logic [15:0] rdata;
  } heoc_state_s;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } heoc_bus_s;

endpackage

// >>> rtl/heoc_top.sv
// Option decoding and transmit control of a code hopping encoder
`timescale 1ns/1ps

// Overview of operation
// - Rate bits select pulse width 400/200/200/100
// - Dual counters only with learn words off
// - Learn words replace hop code when selected
// - Code 1001 immediate, 0011 after delay
// - Delayed words invert discrimination low nibble
// - Delay after 28 or 56 words
// - Shutoff drops output and indicator until release
// - Shutoff after 256 or 512 words
// - Counter B for codes 8-15 in dual
// - IR codes C-F get 40 kHz carrier in dual
// - User bits placed in discrimination value
// - Short serial swaps top nibble for code
// - Temporary learn stops after set hop count
// - Buttons form code, highest is MSB
// - Biphase select picks Manchester or pulse width
// - Sync counter is 16 bits, wraps
// - Wrap flag cleared once, never set again
// - Used counter advances every transmission except immediate learn code 1001
module heoc_top
  import heoc_pkg::*;
#(
  parameter int unsigned TE_SLOW_CYCLES = TE_SLOW_CYC,
  parameter int unsigned TE_MID_CYCLES  = TE_MID_CYC,
  parameter int unsigned TE_FAST_CYCLES = TE_FAST_CYC
) (
  input  wire logic        clock,
  input  wire logic        nrst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic      [15:0] rdata,
  input  wire logic [3:0]  buttons,
  input  wire logic        bit_valid,
  input  wire logic        bit_data,
  output logic             bit_ready,
  input  wire logic        word_end,
  output logic             tx_out,
  output logic             indicator_output_n,
  output logic             send_learn,
  output logic             counter_b_sel,
  output logic      [15:0] sync_value,
  output logic      [11:0] disc_value,
  output logic      [31:0] serial_field,
  output logic      [3:0]  function_code,
  output logic             session_active
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] te_cycles(input logic [15:0] c);
    logic [1:0] r;
    r = {c[CFG_RATE1], c[CFG_RATE0]};
    case (r)
      2'b00:   te_cycles = 16'(TE_SLOW_CYCLES);
      2'b11:   te_cycles = 16'(TE_FAST_CYCLES);
      default: te_cycles = 16'(TE_MID_CYCLES);
    endcase
  endfunction

  function automatic logic use_b(input logic [15:0] c, input logic [3:0] code);
    use_b = c[CFG_DUAL] & ~c[CFG_LEARN] & code[3];
  endfunction

  function automatic logic [7:0] learn_limit(input logic [15:0] v);
    if (v == LIM_KEY_64) begin
      learn_limit = LIM_64;
    end else if (v == LIM_KEY_32) begin
      learn_limit = LIM_32;
    end else if (v == LIM_KEY_16) begin
      learn_limit = LIM_16;
    end else begin
      learn_limit = LIM_128;
    end
  endfunction

  heoc_state_s s_q;
  heoc_state_s s_d;
  heoc_bus_s   bus;

  logic        dual_eff;
  logic        ir_mode;
  logic        learn_ok;
  logic        wrap_eff;
  logic [1:0]  user_bits;
  logic [15:0] te_now;
  logic [1:0]  last_slot;
  logic        level;

  assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

  // ----------------------------------------------------------------
  // Session decode
  // ----------------------------------------------------------------
  assign wrap_eff  = s_q.cfg[CFG_WRAP] & ~s_q.wrapped;
  assign dual_eff  = s_q.sess[CFG_DUAL] & ~s_q.sess[CFG_LEARN];
  assign ir_mode   = dual_eff & (s_q.code[3:2] == 2'b11);
  assign learn_ok  = s_q.sess[CFG_LEARN] & ~(s_q.sess[CFG_TMP] & s_q.learn_off);
  assign user_bits = counter_b_sel ? s_q.sess[CFG_USER_BITS_B +: 2] : s_q.sess[CFG_USER_BITS_A +: 2];
  assign te_now    = te_cycles(s_q.sess);
  assign last_slot = s_q.sess[CFG_BIPHASE_SELECT] ? 2'd1 : 2'd2;

  // Slot level: pulse width is high, ~bit, low; biphase is bit, ~bit
  always_comb begin
    if (s_q.sess[CFG_BIPHASE_SELECT]) begin
      level = (s_q.slot == 2'd0) ? s_q.bit_val : ~s_q.bit_val;
    end else begin
      case (s_q.slot)
        2'd0:    level = 1'b1;
        2'd1:    level = ~s_q.bit_val;
        default: level = 1'b0;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] ncfg;
    logic [9:0]  nwords;
    logic        b_sel;
    logic        wake;
    ncfg   = '0;
    nwords = '0;
    b_sel  = 1'b0;
    wake   = 1'b0;
    s_d    = s_q;
    s_d.rdata = '0;

    // Register writes
    if (bus.wr) begin
      if (bus.addr == REG_CONFIG) begin
        s_d.cfg = bus.wdata;
      end else if (bus.addr == REG_SYNC_A) begin
        s_d.sync_a    = bus.wdata;
        s_d.hop_cnt   = '0;
        s_d.learn_lim = learn_limit(bus.wdata);
      end else if (bus.addr == REG_SYNC_B) begin
        s_d.sync_b    = bus.wdata;
        s_d.hop_cnt   = '0;
        s_d.learn_lim = learn_limit(bus.wdata);
      end else if (bus.addr == REG_SER_LO) begin
        s_d.ser_lo = bus.wdata;
      end else if (bus.addr == REG_SER_HI) begin
        s_d.ser_hi = bus.wdata;
      end
    end

    // Register reads, data in the next cycle only
    if (bus.rd) begin
      if (bus.addr == REG_CONFIG) begin
        s_d.rdata = {wrap_eff, s_q.cfg[14:0]};
      end else if (bus.addr == REG_SYNC_A) begin
        s_d.rdata = s_q.sync_a;
      end else if (bus.addr == REG_SYNC_B) begin
        s_d.rdata = s_q.sync_b;
      end else if (bus.addr == REG_SER_LO) begin
        s_d.rdata = s_q.ser_lo;
      end else if (bus.addr == REG_SER_HI) begin
        s_d.rdata = s_q.ser_hi;
      end else if (bus.addr == REG_STATUS) begin
        s_d.rdata = {s_q.st, s_q.delayed, s_q.learn_off, s_q.wrapped, s_q.words};
      end else if (bus.addr == REG_HOPCNT) begin
        s_d.rdata = {s_q.learn_lim, s_q.hop_cnt};
      end
    end

    // Carrier runs free
    if (s_q.car_cnt == 16'(CAR_HALF_CYC - 1)) begin
      s_d.car_cnt = '0;
      s_d.car     = ~s_q.car;
    end else begin
      s_d.car_cnt = s_q.car_cnt + 16'h0001;
    end

    // Bit encoder
    if (s_q.busy) begin
      if (s_q.te_cnt == 16'h0000) begin
        s_d.te_cnt = te_now - 16'h0001;
        if (s_q.slot == last_slot) begin
          s_d.busy = 1'b0;
        end else begin
          s_d.slot = s_q.slot + 2'd1;
        end
      end else begin
        s_d.te_cnt = s_q.te_cnt - 16'h0001;
      end
    end else if (bit_ready && bit_valid) begin
      s_d.busy    = 1'b1;
      s_d.bit_val = bit_data;
      s_d.slot    = '0;
      s_d.te_cnt  = te_now - 16'h0001;
    end

    // Session control
    case (s_q.st)
      HEOC_IDLE: begin
        wake = (buttons != 4'h0);
      end
      HEOC_ACT: begin
        if (buttons != 4'h0 && buttons != s_q.code) begin
          wake = 1'b1;
        end else if (word_end) begin
          nwords = (s_q.words == WORDS_MAX) ? WORDS_MAX : s_q.words + 10'h001;
          s_d.words = nwords;
          if (s_q.sess[CFG_DELAYED_MODE_ENABLE]
              && nwords == (s_q.sess[CFG_RATE0] ? DELAY_WORDS_HI : DELAY_WORDS_LO)) begin
            s_d.delayed = 1'b1;
          end
          if (s_q.sess[CFG_SHUT]
              && nwords >= (s_q.sess[CFG_RATE0] ? SHUT_WORDS_HI : SHUT_WORDS_LO)) begin
            s_d.st   = HEOC_SHUT;
            s_d.busy = 1'b0;
          end else if (buttons == 4'h0) begin
            s_d.st   = HEOC_IDLE;
            s_d.busy = 1'b0;
          end
        end
      end
      HEOC_SHUT: begin
        s_d.busy = 1'b0;
        if (buttons == 4'h0) begin
          s_d.st = HEOC_IDLE;
        end
      end
      default: begin
        s_d.st = HEOC_IDLE;
      end
    endcase

    // Wake: latch options and advance the counter in use, unless sending learn code 1001
    if (wake) begin
      ncfg        = {wrap_eff, s_d.cfg[14:0]};
      s_d.st      = HEOC_ACT;
      s_d.sess    = ncfg;
      s_d.code    = buttons;
      s_d.words   = '0;
      s_d.delayed = 1'b0;
      s_d.busy    = 1'b0;
      b_sel       = use_b(ncfg, buttons);
      if (!(ncfg[CFG_LEARN] && !(ncfg[CFG_TMP] && s_q.learn_off)
            && buttons == CODE_LEARN_NOW)) begin
        if (b_sel) begin
          s_d.sync_b = s_d.sync_b + 16'h0001;
          if (s_d.sync_b == 16'h0000) begin
            s_d.wrapped = 1'b1;
          end
        end else begin
          s_d.sync_a = s_d.sync_a + 16'h0001;
          if (s_d.sync_a == 16'h0000) begin
            s_d.wrapped = 1'b1;
          end
        end
        if (ncfg[CFG_TMP] && !s_q.learn_off) begin
          s_d.hop_cnt = s_d.hop_cnt + 8'h01;
          if (s_d.hop_cnt >= s_d.learn_lim) begin
            s_d.learn_off = 1'b1;
          end
        end
      end
      s_d.sess[CFG_WRAP] = ncfg[CFG_WRAP] & ~s_d.wrapped;
    end

    // Transmit pin, registered; low outside an active session
    s_d.tx = (s_d.st == HEOC_ACT) && s_q.busy && level && (!ir_mode || s_q.car);
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '{st: HEOC_IDLE, cfg: CFG_RESET, learn_lim: LIM_128, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign rdata              = s_q.rdata;
  assign tx_out             = s_q.tx;
  assign session_active     = (s_q.st == HEOC_ACT);
  assign indicator_output_n = ~session_active;
  assign bit_ready          = session_active && !s_q.busy;
  assign function_code      = s_q.code;
  assign counter_b_sel      = use_b(s_q.sess, s_q.code);
  assign sync_value         = counter_b_sel ? s_q.sync_b : s_q.sync_a;
  assign send_learn         = session_active && learn_ok
                              && (s_q.code == CODE_LEARN_NOW
                                  || (s_q.code == CODE_LEARN_DELAY && s_q.delayed));
  assign disc_value         = {user_bits, s_q.sess[CFG_WRAP], dual_eff, s_q.ser_lo[7:4],
                               s_q.ser_lo[3:0] ^ {4{s_q.delayed}}};
  assign serial_field       = s_q.sess[CFG_LONG_SERIAL_ENABLE] ? {s_q.ser_hi, s_q.ser_lo}
                              : {s_q.code, s_q.ser_hi[11:0], s_q.ser_lo};

endmodule // heoc_top

// >>> test/heoc_top_asserts.sv
// Port assertions for the option control block
`timescale 1ns/1ps
module heoc_top_asserts
  import heoc_pkg::*;
#(
  parameter int unsigned TE_SLOW_CYCLES = TE_SLOW_CYC,
  parameter int unsigned TE_MID_CYCLES  = TE_MID_CYC,
  parameter int unsigned TE_FAST_CYCLES = TE_FAST_CYC
) (
  input wire logic        clock,
  input wire logic        nrst,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic [3:0]  buttons,
  input wire logic        bit_valid,
  input wire logic        bit_ready,
  input wire logic        tx_out,
  input wire logic        indicator_output_n,
  input wire logic        send_learn,
  input wire logic        counter_b_sel,
  input wire logic [15:0] sync_value,
  input wire logic [11:0] disc_value,
  input wire logic [3:0]  function_code,
  input wire logic        session_active
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);

  property p_rdata_idle; !$past(rd) |-> rdata == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside read slot");
  property p_ready_act; bit_ready |-> session_active; endproperty
  a_ready_act: assert property (p_ready_act) else $error("bit taken outside session");
  property p_ready_gap; bit_valid && bit_ready |=> !bit_ready [*3]; endproperty
  a_ready_gap: assert property (p_ready_gap) else $error("encoder ready too soon");
  property p_ind_on; session_active |-> !indicator_output_n; endproperty
  a_ind_on: assert property (p_ind_on) else $error("indicator off in session");
  property p_ind_off; !session_active |-> indicator_output_n; endproperty
  a_ind_off: assert property (p_ind_off) else $error("indicator on outside session");
  property p_tx_quiet; !session_active [*2] |-> !tx_out; endproperty
  a_tx_quiet: assert property (p_tx_quiet) else $error("transmit high outside session");
  property p_learn_dual; send_learn |-> !counter_b_sel; endproperty
  a_learn_dual: assert property (p_learn_dual) else $error("counter B with learn words");
  property p_code_b; counter_b_sel |-> function_code[3]; endproperty
  a_code_b: assert property (p_code_b) else $error("counter B for low code");
  property p_wake_code;
    $rose(session_active) |-> function_code == $past(buttons) && $past(buttons) != 4'h0;
  endproperty
  a_wake_code: assert property (p_wake_code) else $error("function code not buttons");
  property p_wrap;
    $rose(session_active) && !send_learn && sync_value == 16'h0000 |-> !disc_value[9];
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrap flag kept after rollover");
  property p_sync_hold;
    session_active && $past(session_active) && $stable(function_code) |-> $stable(sync_value);
  endproperty
  a_sync_hold: assert property (p_sync_hold) else $error("counter moved mid session");
endmodule // heoc_top_asserts

// >>> test/heoc_rx_model.sv
// Receiver model measuring high runs on the transmit line
`timescale 1ns/1ps
module heoc_rx_model (
  input wire logic clock,
  input wire logic nrst,
  input wire logic tx_out,
  output int       high_len,
  output int       high_total
);
  int run_q;

  // Length of the last completed high pulse, in clocks
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      run_q <= 0;
      high_len <= 0;
    end else if (tx_out) begin
      run_q <= run_q + 1;
    end else if (run_q != 0) begin
      high_len <= run_q;
      run_q <= 0;
    end
  end

  // Count of clocks with the line high
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      high_total <= 0;
    end else if (tx_out) begin
      high_total <= high_total + 1;
    end
  end
endmodule // heoc_rx_model

// >>> test/tb.sv
// Self-checking bench for the option control block
`timescale 1ns/1ps
module tb;
  import heoc_pkg::*;
  localparam int TS = 8;
  localparam int TM = 4;
  localparam int TF = 2;
  logic clock = 1'b0;
  logic nrst = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] buttons = 4'h0;
  logic bit_valid = 1'b0;
  logic bit_data = 1'b0;
  logic word_end = 1'b0;
  logic [15:0] rdata, sync_value, rv;
  logic [11:0] disc_value;
  logic [31:0] serial_field;
  logic [3:0] function_code;
  logic bit_ready, tx_out, indicator_output_n, send_learn, counter_b_sel, session_active;
  int errors = 0;
  int tests_run = 0;
  int cycles = 0;
  int high_len;
  int high_total;

  always #5 clock = ~clock;

  heoc_top #(.TE_SLOW_CYCLES(TS), .TE_MID_CYCLES(TM), .TE_FAST_CYCLES(TF)) DUT (
    .clock, .nrst, .addr, .wdata, .wr, .rd, .rdata, .buttons, .bit_valid, .bit_data,
    .bit_ready, .word_end, .tx_out, .indicator_output_n, .send_learn, .counter_b_sel,
    .sync_value, .disc_value, .serial_field, .function_code, .session_active);
  heoc_rx_model u_rx (.clock, .nrst, .tx_out, .high_len, .high_total);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("errors=%0d tests_run=%0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clock);
    wr <= 1'b0;
  endtask
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd <= 1'b1;
    @(posedge clock);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic word();
    @(posedge clock);
    word_end <= 1'b1;
    @(posedge clock);
    word_end <= 1'b0;
    #1;
  endtask
  task automatic press(input logic [3:0] code);
    @(posedge clock);
    buttons <= code;
    repeat (2) @(posedge clock);
    #1;
  endtask
  task automatic let_go();
    @(posedge clock);
    buttons <= 4'h0;
    word();
    chk(session_active, 1'b0);
  endtask
  task automatic send_bit(input logic b, input int exp);
    for (int n = 0; n < 100 && bit_ready !== 1'b1; n++) @(posedge clock) #1;
    @(posedge clock);
    bit_valid <= 1'b1;
    bit_data <= b;
    @(posedge clock);
    bit_valid <= 1'b0;
    #1;
    for (int n = 0; n < 100 && bit_ready !== 1'b1; n++) @(posedge clock) #1;
    repeat (3) @(posedge clock);
    chk(high_len, exp);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd_reg(REG_CONFIG, rv);
    chk(rv, 16'h0000);
    rd_reg(REG_STATUS, rv);
    chk(rv, 16'h2000);
    wr_reg(REG_CONFIG, 16'h5A5A);
    rd_reg(REG_CONFIG, rv);
    chk(rv, 16'h5A5A);
    wr_reg(4'hF, 16'hFFFF);
    rd_reg(4'hF, rv);
    chk(rv, 16'h0000);
  endtask
  task automatic t_rate();
    int te;
    for (int r = 0; r < 4; r++) begin
      te = (r == 0) ? TS : (r == 3) ? TF : TM;
      wr_reg(REG_CONFIG, 16'(r << CFG_RATE0));
      press(4'h1);
      send_bit(1'b1, te);
      send_bit(1'b0, 2 * te);
      let_go();
    end
    wr_reg(REG_CONFIG, 16'h4006);
    press(4'h2);
    send_bit(1'b0, TF);
    let_go();
  endtask
  task automatic t_counter();
    wr_reg(REG_CONFIG, 16'h0C80);
    wr_reg(REG_SYNC_A, 16'h0010);
    wr_reg(REG_SYNC_B, 16'h0200);
    press(4'h8);
    chk(counter_b_sel, 1'b1);
    chk(sync_value, 16'h0201);
    chk(disc_value[11:8], 4'hD);
    let_go();
    press(4'h7);
    chk(counter_b_sel, 1'b0);
    chk(sync_value, 16'h0011);
    chk(disc_value[11:8], 4'h1);
    let_go();
    wr_reg(REG_CONFIG, 16'h0000);
    press(4'hF);
    chk(counter_b_sel, 1'b0);
    chk(sync_value, 16'h0012);
    let_go();
  endtask
  task automatic t_learn();
    logic [15:0] keys [4] = '{16'h0000, 16'h0060, 16'h0050, 16'h0048};
    logic [7:0] lims [4] = '{8'h80, 8'h40, 8'h20, 8'h10};
    wr_reg(REG_CONFIG, 16'h0090);
    press(4'h9);
    chk(send_learn, 1'b1);
    chk(counter_b_sel, 1'b0);
    let_go();
    press(4'h3);
    chk(send_learn, 1'b0);
    let_go();
    foreach (keys[i]) begin
      wr_reg(REG_SYNC_A, keys[i]);
      rd_reg(REG_HOPCNT, rv);
      chk(rv, {lims[i], 8'h00});
    end
    wr_reg(REG_CONFIG, 16'h2010);
    repeat (15) begin
      press(4'h1);
      let_go();
    end
    press(4'h9);
    chk(send_learn, 1'b1);
    let_go();
    press(4'h1);
    let_go();
    press(4'h9);
    chk(send_learn, 1'b0);
    let_go();
  endtask
  task automatic t_serial();
    wr_reg(REG_SER_HI, 16'hABCD);
    wr_reg(REG_SER_LO, 16'h1234);
    wr_reg(REG_CONFIG, 16'h0000);
    press(4'h5);
    chk(serial_field, {4'h5, 12'hBCD, 16'h1234});
    chk(function_code, 4'h5);
    let_go();
    wr_reg(REG_CONFIG, 16'h1300);
    press(4'h5);
    chk(serial_field, 32'hABCD1234);
    chk(disc_value, 12'hC34);
    let_go();
  endtask
  task automatic t_wrap();
    wr_reg(REG_CONFIG, 16'h8000);
    wr_reg(REG_SYNC_A, 16'hFFFE);
    press(4'h1);
    chk(disc_value[9], 1'b1);
    let_go();
    press(4'h1);
    chk(sync_value, 16'h0000);
    chk(disc_value[9], 1'b0);
    let_go();
    wr_reg(REG_CONFIG, 16'h8000);
    rd_reg(REG_CONFIG, rv);
    chk(rv[15], 1'b0);
  endtask
  task automatic t_shut();
    int dw;
    int sw;
    for (int r = 0; r < 2; r++) begin
      dw = r ? 56 : 28;
      sw = r ? 512 : 256;
      wr_reg(REG_CONFIG, 16'h0060 | 16'(r << CFG_RATE0));
      press(4'h2);
      repeat (dw - 1) word();
      chk(disc_value[3:0], 4'h4);
      word();
      chk(disc_value[3:0], 4'hB);
      repeat (sw - dw - 1) word();
      chk(session_active, 1'b1);
      word();
      chk({session_active, indicator_output_n, tx_out}, 3'b010);
      rd_reg(REG_STATUS, rv);
      chk(rv[15:13], 3'h4);
      let_go();
      rd_reg(REG_STATUS, rv);
      chk(rv[15:13], 3'h1);
    end
  endtask
  // Carrier roughly halves the high time of a long burst
  task automatic t_ir();
    int h0;
    logic [3:0] codes [2] = '{4'h8, 4'hC};
    wr_reg(REG_CONFIG, 16'h0080);
    foreach (codes[i]) begin
      press(codes[i]);
      h0 = high_total;
      repeat (110) begin
        for (int n = 0; n < 100 && bit_ready !== 1'b1; n++) @(posedge clock) #1;
        @(posedge clock);
        bit_valid <= 1'b1;
        bit_data <= 1'b0;
        @(posedge clock);
        bit_valid <= 1'b0;
        #1;
      end
      chk(high_total - h0 < 1200, i == 1);
      let_go();
    end
  endtask

  initial begin
    repeat (8) @(posedge clock);
    nrst <= 1'b1;
    t_regs();
    t_rate();
    t_counter();
    t_learn();
    t_serial();
    t_wrap();
    t_shut();
    t_ir();
    tally_and_finish();
  end

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      errors++;
      $display("mismatch at %0t: timeout", $time);
      tally_and_finish();
    end
  end
endmodule // tb

bind heoc_top heoc_top_asserts #(.TE_SLOW_CYCLES(TE_SLOW_CYCLES),
  .TE_MID_CYCLES(TE_MID_CYCLES), .TE_FAST_CYCLES(TE_FAST_CYCLES)) u_asserts (
  .clock, .nrst, .rd, .rdata, .buttons, .bit_valid, .bit_ready, .tx_out,
  .indicator_output_n, .send_learn, .counter_b_sel, .sync_value, .disc_value,
  .function_code, .session_active);
